// ==== design/fpdc_display_ctrl.sv ====
// front panel display control: remote command interpreter for the display settings
// assumes commands come from a parser on MCLK; keys, firmware match and saved setup are pins
`timescale 1ns/1ps
module fpdc_display_ctrl
(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic CMD_VALID,
	input wire fpdc_pkg::fpdc_cmd_type CMD_CODE,
	input wire logic [2:0] CMD_ARG,
	output logic RESP_VALID,
	output logic RESP_BIT,
	output logic ERR_VALID,
	output logic [15:0] ERR_CODE,
	input wire logic FW_COMPAT,
	input wire logic SAVED_DIAG_MODE,
	input wire logic [fpdc_pkg::FPDC_CHANNELS-1:0] CHAN_AVAIL,
	input wire logic [fpdc_pkg::FPDC_CHANNELS-1:0] CHAN_CLOSED,
	output logic [2*fpdc_pkg::FPDC_CHANNELS-1:0] LED_LEVEL,
	input wire logic STAT_MSG_VALID,
	input wire logic STAT_MSG_IS_ERR,
	output logic MSG_SHOW,
	output logic DISP_FROZEN,
	input wire logic KEY_LOCAL,
	input wire logic [fpdc_pkg::FPDC_KEYS-1:0] PANEL_KEYS,
	output logic [fpdc_pkg::FPDC_KEYS-1:0] KEYS_OUT,
	output logic LOCAL_OUT
);
	import fpdc_pkg::*;

	localparam int SYNC_W = FPDC_KEYS + 3;

	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic fw_ok;
	logic saved_diag;
	logic local_key;
	logic [FPDC_KEYS-1:0] keys;
	logic gratic_reg;
	logic diag_message_mode_reg;
	logic enab_reg;
	logic resp_valid_reg;
	logic resp_bit_reg;
	logic err_valid_reg;
	logic [15:0] err_code_reg;
	logic msg_show_reg;
	logic [FPDC_KEYS-1:0] keys_out_reg;
	logic local_out_reg;
	logic arg_ok;
	logic arg_val;
	logic go_local;
	logic soft_reset;

	fpdc_led_if led_path();

	// two flops on every pin; only the second stage is read
	always_ff @(posedge MCLK)
	begin
		sync1_reg <= {FW_COMPAT, SAVED_DIAG_MODE, KEY_LOCAL, PANEL_KEYS};
		sync2_reg <= sync1_reg;
	end

	assign fw_ok = sync2_reg[SYNC_W-1];
	assign saved_diag = sync2_reg[SYNC_W-2];
	assign local_key = sync2_reg[SYNC_W-3];
	assign keys = sync2_reg[FPDC_KEYS-1:0];

	// parameter decode shared by all set commands
	assign arg_ok = fpdc_tok_legal(CMD_ARG);
	assign arg_val = fpdc_tok_value(CMD_ARG);
	assign go_local = local_key || (CMD_VALID && CMD_CODE == CMD_GO_LOCAL);
	assign soft_reset = CMD_VALID && (CMD_CODE == CMD_RESET || CMD_CODE == CMD_PRESET);

	// background mode; a mismatched firmware pair refuses a set to off
	always_ff @(posedge MCLK)
	begin
		if (RST || soft_reset)
			gratic_reg <= FPDC_GRAT_DEFAULT;
		else if (CMD_VALID && CMD_CODE == CMD_GRAT_SET && arg_ok)
		begin
			if (arg_val || fw_ok)
				gratic_reg <= arg_val;
		end
	end

	// diagnostic mode; the saved setup pin is already synchronised when reset samples it
	always_ff @(posedge MCLK)
	begin
		if (RST)
			diag_message_mode_reg <= saved_diag;
		else if (soft_reset)
			diag_message_mode_reg <= FPDC_DIAG_RESET;
		else if (CMD_VALID && CMD_CODE == CMD_DIAG_SET && arg_ok)
			diag_message_mode_reg <= arg_val;
	end

	// display enable; going to local wins over a disable in the same cycle
	always_ff @(posedge MCLK)
	begin
		if (RST)
			enab_reg <= FPDC_ENAB_POWERUP;
		else if (go_local)
			enab_reg <= 1'b1;
		else if (CMD_VALID && CMD_CODE == CMD_ENAB_SET && arg_ok)
			enab_reg <= arg_val;
	end

	// query answers and errors, one cycle after the command
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			resp_valid_reg <= 1'b0;
			resp_bit_reg <= 1'b0;
			err_valid_reg <= 1'b0;
			err_code_reg <= FPDC_ERR_NONE;
		end
		else
		begin
			resp_valid_reg <= 1'b0;
			err_valid_reg <= 1'b0;
			if (CMD_VALID)
			begin
				case (CMD_CODE)
					CMD_GRAT_QRY:
					begin
						resp_valid_reg <= 1'b1;
						resp_bit_reg <= gratic_reg;
					end
					CMD_DIAG_QRY:
					begin
						resp_valid_reg <= 1'b1;
						resp_bit_reg <= diag_message_mode_reg;
					end
					CMD_ENAB_QRY:
					begin
						resp_valid_reg <= 1'b1;
						resp_bit_reg <= enab_reg;
					end
					CMD_GRAT_SET, CMD_DIAG_SET, CMD_ENAB_SET:
					begin
						if (!arg_ok)
						begin
							err_valid_reg <= 1'b1;
							err_code_reg <= FPDC_ERR_BAD_PARAM;
						end
						else if (CMD_CODE == CMD_GRAT_SET && !arg_val && !fw_ok)
						begin
							err_valid_reg <= 1'b1;
							err_code_reg <= FPDC_ERR_FW_MISMATCH;
						end
					end
					default:
					begin
						resp_valid_reg <= 1'b0;
					end
				endcase
			end
		end
	end

	// status messages: error events always pass, the rest only in diagnostic mode
	always_ff @(posedge MCLK)
	begin
		if (RST)
			msg_show_reg <= 1'b0;
		else
			msg_show_reg <= STAT_MSG_VALID && (diag_message_mode_reg || STAT_MSG_IS_ERR);
	end

	// panel keys are dropped while frozen; local always passes so the user can resume
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			keys_out_reg <= '0;
			local_out_reg <= 1'b0;
		end
		else
		begin
			keys_out_reg <= enab_reg ? keys : '0;
			local_out_reg <= local_key;
		end
	end

	// channel led shaping lives in its own module
	assign led_path.gratic = gratic_reg;
	assign led_path.avail = CHAN_AVAIL;
	assign led_path.closed = CHAN_CLOSED;

	fpdc_led_shaper u_shaper
	(
		.clk(MCLK),
		.rst(RST),
		.led_path(led_path.shaper)
	);

	assign LED_LEVEL = led_path.level;
	assign RESP_VALID = resp_valid_reg;
	assign RESP_BIT = resp_bit_reg;
	assign ERR_VALID = err_valid_reg;
	assign ERR_CODE = err_code_reg;
	assign MSG_SHOW = msg_show_reg;
	assign DISP_FROZEN = !enab_reg;
	assign KEYS_OUT = keys_out_reg;
	assign LOCAL_OUT = local_out_reg;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	sequence seq_grat_off_cmd;
		CMD_VALID && CMD_CODE == CMD_GRAT_SET && fpdc_tok_legal(CMD_ARG) && !fpdc_tok_value(CMD_ARG);
	endsequence

	sequence seq_fw_error;
		ERR_VALID && ERR_CODE == FPDC_ERR_FW_MISMATCH;
	endsequence

	// the refused disable must leave the mode as it was, which need not be on
	AST_FW_MISMATCH_ERR:
	assert property (seq_grat_off_cmd ##0 !fw_ok |=> seq_fw_error ##0 $stable(gratic_reg))
		else $error("firmware mismatch did not raise error or changed mode");
	AST_GRAT_QUERY:
	assert property (CMD_VALID && CMD_CODE == CMD_GRAT_QRY |=> RESP_VALID && RESP_BIT == $past(gratic_reg))
		else $error("background query answer wrong");
	AST_DIAG_RESET_OFF:
	assert property (soft_reset |=> !diag_message_mode_reg && gratic_reg)
		else $error("reset or preset did not restore modes");
	AST_ENAB_KEEP_ON_RESET:
	assert property (soft_reset && !go_local |=> enab_reg == $past(enab_reg))
		else $error("reset or preset changed display enable");
	AST_BAD_PARAM:
	assert property (CMD_VALID && CMD_CODE == CMD_DIAG_SET && !arg_ok && !soft_reset
		|=> ERR_VALID && ERR_CODE == FPDC_ERR_BAD_PARAM && $stable(diag_message_mode_reg))
		else $error("illegal parameter accepted");
	AST_MSG_GATE:
	assert property (STAT_MSG_VALID && !STAT_MSG_IS_ERR && !diag_message_mode_reg |=> !MSG_SHOW)
		else $error("status message shown with diagnostic mode off");
	AST_KEYS_FROZEN:
	assert property (DISP_FROZEN |=> KEYS_OUT == '0)
		else $error("panel key passed while display disabled");
	AST_LOCAL_RESUME:
	assert property (local_key |=> !DISP_FROZEN ##1 (!DISP_FROZEN || !local_key))
		else $error("local did not resume the display");
endmodule // fpdc_display_ctrl

// ==== design/fpdc_led_shaper.sv ====
// front panel display control: per-channel led level shaper
// assumes avail/closed come from logic on the same clock
`timescale 1ns/1ps
module fpdc_led_shaper
(
	input wire logic clk,
	input wire logic rst,
	fpdc_led_if.shaper led_path
);
	import fpdc_pkg::*;

	logic [2*FPDC_CHANNELS-1:0] level_reg;

	// available closed channels bright; open available ones dim only with the background on
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < FPDC_CHANNELS; i++)
		begin
			if (rst || !led_path.avail[i])
				level_reg[2*i +: 2] <= LED_OFF;
			else if (led_path.closed[i])
				level_reg[2*i +: 2] <= LED_BRIGHT;
			else if (led_path.gratic)
				level_reg[2*i +: 2] <= LED_DIM;
			else
				level_reg[2*i +: 2] <= LED_OFF;
		end
	end

	assign led_path.level = level_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_LED_UNAVAIL_OFF:
	assert property (!led_path.avail[0] |=> led_path.level[1:0] == LED_OFF)
		else $error("unavailable channel led not off");
	AST_LED_AVAIL_LIT:
	assert property (led_path.gratic && led_path.avail[0] |=> led_path.level[1:0] != LED_OFF)
		else $error("available channel led not lit with background on");
	AST_LED_NO_DIM:
	assert property (!led_path.gratic |=> led_path.level[1:0] != LED_DIM)
		else $error("dim led while background mode off");
endmodule // fpdc_led_shaper

// ==== dv/fpdc_display_ctrl_bench.sv ====
// front panel display control: self-checking bench for the display command interpreter
// assumes fpdc_host_model drives the command port; pins are driven 1 ns after MCLK rises
`timescale 1ns/1ps
module fpdc_display_ctrl_bench;
	import fpdc_pkg::*;
	logic MCLK, RST, CMD_VALID, RESP_VALID, RESP_BIT, ERR_VALID, FW_COMPAT, SAVED_DIAG_MODE;
	logic STAT_MSG_VALID, STAT_MSG_IS_ERR, MSG_SHOW, DISP_FROZEN, KEY_LOCAL, LOCAL_OUT;
	fpdc_cmd_type CMD_CODE;
	logic [2:0] CMD_ARG;
	logic [15:0] ERR_CODE, LED_LEVEL, ec;
	logic [7:0] CHAN_AVAIL, CHAN_CLOSED, PANEL_KEYS, KEYS_OUT;
	logic rv, rb, ev;
	int mismatches, cmp_count;

	fpdc_display_ctrl dut (.MCLK(MCLK), .RST(RST), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE),
		.CMD_ARG(CMD_ARG), .RESP_VALID(RESP_VALID), .RESP_BIT(RESP_BIT), .ERR_VALID(ERR_VALID),
		.ERR_CODE(ERR_CODE), .FW_COMPAT(FW_COMPAT), .SAVED_DIAG_MODE(SAVED_DIAG_MODE),
		.CHAN_AVAIL(CHAN_AVAIL),
		.CHAN_CLOSED(CHAN_CLOSED), .LED_LEVEL(LED_LEVEL), .STAT_MSG_VALID(STAT_MSG_VALID),
		.STAT_MSG_IS_ERR(STAT_MSG_IS_ERR), .MSG_SHOW(MSG_SHOW), .DISP_FROZEN(DISP_FROZEN),
		.KEY_LOCAL(KEY_LOCAL), .PANEL_KEYS(PANEL_KEYS), .KEYS_OUT(KEYS_OUT), .LOCAL_OUT(LOCAL_OUT));
	fpdc_host_model host (.MCLK(MCLK), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .CMD_ARG(CMD_ARG),
		.RESP_VALID(RESP_VALID), .RESP_BIT(RESP_BIT), .ERR_VALID(ERR_VALID), .ERR_CODE(ERR_CODE));

	// verdict and end of run, also reached when a bounded wait runs out
	task automatic complete_run();
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk16({15'h0, got}, {15'h0, exp});
	endtask
	task automatic cmd(input fpdc_cmd_type code, input logic [2:0] arg);
		host.issue(code, arg, 0, rv, rb, ev, ec);
	endtask
	// a query must answer with one strobe and the expected bit
	task automatic query(input fpdc_cmd_type code, input logic exp);
		host.issue(code, 3'h0, 1, rv, rb, ev, ec);
		chk1(rv, 1'b1);
		chk1(rb, exp);
	endtask
	// expected led word: unavailable off, closed bright, open dim only with background on
	function automatic logic [15:0] led_exp(input logic [7:0] av, input logic [7:0] cl, input logic bg);
		led_exp = 16'h0;
		for (int i = 0; i < 8; i++)
			led_exp[2*i +: 2] = !av[i] ? LED_OFF : (cl[i] ? LED_BRIGHT : (bg ? LED_DIM : LED_OFF));
	endfunction
	task automatic msg(input logic is_err, input logic exp);
		@(posedge MCLK);
		#1;
		STAT_MSG_VALID = 1'b1;
		STAT_MSG_IS_ERR = is_err;
		@(posedge MCLK);
		#1;
		STAT_MSG_VALID = 1'b0;
		chk1(MSG_SHOW, exp);
	endtask

	task automatic t_defaults();
		query(CMD_GRAT_QRY, 1'b1);
		query(CMD_DIAG_QRY, 1'b1);
		query(CMD_ENAB_QRY, 1'b1);
		chk1(DISP_FROZEN, 1'b0);
	endtask
	// every token in turn; channels 6 and 7 closed but unavailable
	task automatic t_grat();
		CHAN_AVAIL = 8'h3f;
		CHAN_CLOSED = 8'hc5;
		for (int t = 0; t < 4; t++)
		begin
			cmd(CMD_GRAT_SET, 3'(t));
			chk1(ev, 1'b0);
			query(CMD_GRAT_QRY, t[0]);
			chk16(LED_LEVEL, led_exp(CHAN_AVAIL, CHAN_CLOSED, t[0]));
		end
	endtask
	task automatic t_fw();
		FW_COMPAT = 1'b0;
		repeat (3) @(posedge MCLK);
		cmd(CMD_GRAT_SET, TOK_OFF);
		chk1(ev, 1'b1);
		chk16(ec, 16'h0227);
		query(CMD_GRAT_QRY, 1'b1);
		cmd(CMD_GRAT_SET, TOK_ON);
		chk1(ev, 1'b0);
		FW_COMPAT = 1'b1;
	endtask
	// illegal tokens on each set command leave all settings on
	task automatic t_badtok();
		for (int a = 4; a < 8; a++)
		begin
			cmd(fpdc_cmd_type'(4'(2 * (a % 3))), 3'(a));
			chk1(ev, 1'b1);
			chk16(ec, 16'hff20);
			query(fpdc_cmd_type'(4'(2 * (a % 3) + 1)), 1'b1);
		end
	endtask
	// reset and preset each start from background off, diagnostic on, display off
	task automatic t_diag();
		cmd(CMD_DIAG_SET, TOK_ON);
		query(CMD_DIAG_QRY, 1'b1);
		msg(1'b0, 1'b1);
		cmd(CMD_DIAG_SET, TOK_ZERO);
		query(CMD_DIAG_QRY, 1'b0);
		msg(1'b0, 1'b0);
		msg(1'b1, 1'b1);
		cmd(CMD_GRAT_SET, TOK_ZERO);
		cmd(CMD_DIAG_SET, TOK_ONE);
		cmd(CMD_ENAB_SET, TOK_OFF);
		cmd(CMD_RESET, 3'h0);
		query(CMD_GRAT_QRY, 1'b1);
		query(CMD_DIAG_QRY, 1'b0);
		query(CMD_ENAB_QRY, 1'b0);
		cmd(CMD_GRAT_SET, TOK_OFF);
		cmd(CMD_DIAG_SET, TOK_ON);
		cmd(CMD_PRESET, 3'h0);
		query(CMD_GRAT_QRY, 1'b1);
		query(CMD_DIAG_QRY, 1'b0);
		query(CMD_ENAB_QRY, 1'b0);
		cmd(CMD_ENAB_SET, TOK_ONE);
		query(CMD_ENAB_QRY, 1'b1);
	endtask
	task automatic t_enab();
		int n;
		PANEL_KEYS = 8'h5a;
		repeat (4) @(posedge MCLK);
		#1;
		chk16({8'h0, KEYS_OUT}, 16'h005a);
		cmd(CMD_ENAB_SET, TOK_OFF);
		chk1(DISP_FROZEN, 1'b1);
		query(CMD_ENAB_QRY, 1'b0);
		PANEL_KEYS = 8'ha5;
		repeat (4) @(posedge MCLK);
		#1;
		chk16({8'h0, KEYS_OUT}, 16'h0000);
		KEY_LOCAL = 1'b1;
		n = 0;
		while (DISP_FROZEN !== 1'b0 && n < 8)
		begin
			@(posedge MCLK);
			#1;
			n++;
		end
		if (n == 8)
		begin
			mismatches++;
			complete_run();
		end
		chk1(LOCAL_OUT, 1'b1);
		KEY_LOCAL = 1'b0;
		// the released key must leave both synchroniser stages, or local still wins over the disable
		repeat (2) @(posedge MCLK);
		cmd(CMD_ENAB_SET, TOK_ZERO);
		chk1(DISP_FROZEN, 1'b1);
		cmd(CMD_GO_LOCAL, 3'h0);
		chk1(DISP_FROZEN, 1'b0);
		cmd(CMD_ENAB_SET, TOK_OFF);
		chk1(DISP_FROZEN, 1'b1);
		cmd(CMD_ENAB_SET, TOK_ON);
		chk1(DISP_FROZEN, 1'b0);
	endtask

	// 250 MHz clock
	initial
	begin
		MCLK = 1'b0;
		forever #2 MCLK = ~MCLK;
	end
	// reset as power-up with the saved diagnostic mode on, then each scenario
	initial
	begin
		mismatches = 0;
		cmp_count = 0;
		RST = 1'b1;
		FW_COMPAT = 1'b1;
		SAVED_DIAG_MODE = 1'b1;
		CHAN_AVAIL = 8'h0;
		CHAN_CLOSED = 8'h0;
		STAT_MSG_VALID = 1'b0;
		STAT_MSG_IS_ERR = 1'b0;
		KEY_LOCAL = 1'b0;
		PANEL_KEYS = 8'h0;
		repeat (8) @(posedge MCLK);
		#1;
		RST = 1'b0;
		t_defaults();
		t_grat();
		t_fw();
		t_badtok();
		t_diag();
		t_enab();
		complete_run();
	end
endmodule // fpdc_display_ctrl_bench

// ==== dv/fpdc_host_model.sv ====
// front panel display control: remote host model issuing display commands
// assumes the controller takes a command on the rising MCLK edge with the strobe high
`timescale 1ns/1ps
module fpdc_host_model
(
	input wire logic MCLK,
	output logic CMD_VALID,
	output fpdc_pkg::fpdc_cmd_type CMD_CODE,
	output logic [2:0] CMD_ARG,
	input wire logic RESP_VALID,
	input wire logic RESP_BIT,
	input wire logic ERR_VALID,
	input wire logic [15:0] ERR_CODE
);
	import fpdc_pkg::*;
	// idle: strobe low, code and argument parked
	initial
	begin
		CMD_VALID = 1'b0;
		CMD_CODE = CMD_GRAT_QRY;
		CMD_ARG = 3'h0;
	end
	// one command after gap + 1 idle cycles; answers sampled in the cycle after the taking edge
	task automatic issue(input fpdc_cmd_type code, input logic [2:0] arg, input int gap,
		output logic rv, output logic rb, output logic ev, output logic [15:0] ec);
		repeat (gap + 1) @(posedge MCLK);
		#1;
		CMD_VALID = 1'b1;
		CMD_CODE = code;
		CMD_ARG = arg;
		@(posedge MCLK);
		#1;
		CMD_VALID = 1'b0;
		// released fields show the inverse so a stale value is never mistaken for a live one
		CMD_CODE = fpdc_cmd_type'(~code);
		CMD_ARG = ~arg;
		rv = RESP_VALID;
		rb = RESP_BIT;
		ev = ERR_VALID;
		ec = ERR_CODE;
	endtask
endmodule // fpdc_host_model

// ==== include/fpdc_led_if.sv ====
// front panel display control: channel led path between controller and shaper
// assumes both ends run on MCLK
`timescale 1ns/1ps
interface fpdc_led_if;
	import fpdc_pkg::*;
	logic gratic;
	logic [FPDC_CHANNELS-1:0] avail;
	logic [FPDC_CHANNELS-1:0] closed;
	logic [2*FPDC_CHANNELS-1:0] level;
	modport ctrl
	(
		output gratic,
		output avail,
		output closed,
		input level
	);
	modport shaper
	(
		input gratic,
		input avail,
		input closed,
		output level
	);
endinterface

// ==== include/fpdc_pkg.sv ====
// front panel display control: shared constants, command and token codes
// assumes one clock domain (MCLK) and a synchronous active-high reset
package fpdc_pkg;
	// channel and key counts of the front panel
	localparam int FPDC_CHANNELS = 8;
	localparam int FPDC_KEYS = 8;
	// commands arriving from the remote command parser
	typedef enum logic [3:0]
	{
		CMD_GRAT_SET = 4'h0,
		CMD_GRAT_QRY = 4'h1,
		CMD_DIAG_SET = 4'h2,
		CMD_DIAG_QRY = 4'h3,
		CMD_ENAB_SET = 4'h4,
		CMD_ENAB_QRY = 4'h5,
		CMD_RESET = 4'h6,
		CMD_PRESET = 4'h7,
		CMD_GO_LOCAL = 4'h8
	} fpdc_cmd_type;
	// boolean parameter tokens; every other code is illegal
	typedef enum logic [2:0]
	{
		TOK_ZERO = 3'h0,
		TOK_ONE = 3'h1,
		TOK_OFF = 3'h2,
		TOK_ON = 3'h3
	} fpdc_tok_type;
	// per-channel led drive level
	typedef enum logic [1:0]
	{
		LED_OFF = 2'h0,
		LED_DIM = 2'h1,
		LED_BRIGHT = 2'h2
	} fpdc_led_type;
	// error codes, two's complement
	localparam logic [15:0] FPDC_ERR_FW_MISMATCH = 16'h0227;
	localparam logic [15:0] FPDC_ERR_BAD_PARAM = 16'hff20;
	localparam logic [15:0] FPDC_ERR_NONE = 16'h0000;
	// values after power-up, reset command and preset
	localparam logic FPDC_GRAT_DEFAULT = 1'b1;
	localparam logic FPDC_DIAG_RESET = 1'b0;
	localparam logic FPDC_ENAB_POWERUP = 1'b1;
	// synchroniser depth for pin inputs
	localparam int FPDC_SYNC_STAGES = 2;

	// legal boolean token test
	function automatic logic fpdc_tok_legal(input logic [2:0] tok);
		fpdc_tok_legal = (tok == TOK_ZERO) || (tok == TOK_ONE) || (tok == TOK_OFF) || (tok == TOK_ON);
	endfunction

	// boolean value of a legal token
	function automatic logic fpdc_tok_value(input logic [2:0] tok);
		fpdc_tok_value = (tok == TOK_ONE) || (tok == TOK_ON);
	endfunction
endpackage
